/* hdl/trs_trace_regs.sv */
// trace buffer status, read data and pointer registers behind APB
//
// Operation
// - status bit 3 is one when formatter pipeline is drained
// - status bit 2 is one while formatter is halted for any cause
// - status bit 1 is one once a trigger was embedded in trace
// - status bit 0 is one once the write pointer has wrapped
// - stopped: read word shows RAM at read pointer; reads advance it
// - read word returns all ones while capture is running
// - such error read leaves the read pointer unchanged
// - read word register is 32 bits of fetched RAM data
// - read pointer write loads it, fetches, then updates read word
// - read pointer in bits 9..0, upper bits reserved zero
// - both pointer registers read back their current location
// - read pointer writes ignored while capture is running
// - write pointer writes ignored while capture is running
// - write pointer advances per formatter valid word during capture
// - write pointer wrap to zero sets the full flag
// - write pointer in bits 9..0, loadable by host write
// - capture enable clear makes formatter flush, then halt
// - depth register reports number of RAM words
`timescale 1ns/1ps
`default_nettype none

module trs_trace_regs (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [trs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [trs_pkg::DATA_W-1:0] pwdata,
  output var  logic [trs_pkg::DATA_W-1:0] prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  input  wire logic                       capture_enable,
  input  wire logic                       formatter_halted,
  input  wire logic                       formatter_pipe_drained,
  input  wire logic                       formatter_word_valid,
  input  wire logic [trs_pkg::DATA_W-1:0] formatter_word,
  input  wire logic                       trigger_embedded
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [trs_pkg::PTR_W-1:0]  rd_ptr_reg;
  logic [trs_pkg::PTR_W-1:0]  rd_ptr_next;
  logic [trs_pkg::PTR_W-1:0]  wr_ptr_reg;
  logic [trs_pkg::PTR_W-1:0]  wr_ptr_next;
  logic [trs_pkg::DATA_W-1:0] read_word_reg;
  logic [trs_pkg::DATA_W-1:0] ram_q;
  logic [trs_pkg::DATA_W-1:0] rdata_next;
  logic                       rdata_err;
  logic                       fetch;
  logic                       fetch_q;
  logic                       running;
  logic                       running_q;
  logic                       access;
  logic                       host_rd;
  logic                       host_wr;
  logic                       word_read;
  logic                       rd_idx_load;
  logic                       wr_idx_load;
  logic                       store;
  logic                       wrap_pulse;
  trs_pkg::trs_status_t       status;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // capture counts as running only while enabled and the formatter is not halted
  assign running     = capture_enable && !formatter_halted;
  assign access      = psel && penable && !pready;
  assign host_rd     = access && !pwrite;
  assign host_wr     = access && pwrite;
  assign word_read   = host_rd && (paddr == trs_pkg::OFF_WORD);
  assign rd_idx_load = host_wr && (paddr == trs_pkg::OFF_RD_IDX) && !running;
  assign wr_idx_load = host_wr && (paddr == trs_pkg::OFF_WR_IDX) && !running;
  assign store       = formatter_word_valid && running;
  assign wrap_pulse  = store && (wr_ptr_reg == trs_pkg::PTR_MAX);

  // ----------------------------------------------------------------
  // read pointer and fetch launch
  // ----------------------------------------------------------------
  always_comb begin
    rd_ptr_next = rd_ptr_reg;
    fetch       = 1'b0;
    if (rd_idx_load) begin
      rd_ptr_next = pwdata[trs_pkg::PTR_W-1:0];
      fetch       = 1'b1;
    end else if (word_read && !running) begin
      rd_ptr_next = rd_ptr_reg + trs_pkg::PTR_ONE;
      fetch       = 1'b1;
    end else if (running_q && !running) begin
      fetch       = 1'b1; // refresh word once capture has stopped
    end
  end

  // pointer register, frozen on error reads
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_ptr_reg <= trs_pkg::PTR_ZERO;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // fetch tracking and capture state history
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fetch_q   <= 1'b0;
      running_q <= 1'b0;
    end else begin
      fetch_q   <= fetch;
      running_q <= running;
    end
  end

  // read word loads one cycle after the RAM access
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      read_word_reg <= trs_pkg::ZERO_WORD;
    end else if (fetch_q) begin
      read_word_reg <= ram_q;
    end
  end

  // ----------------------------------------------------------------
  // write pointer
  // ----------------------------------------------------------------
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    if (wr_idx_load) begin
      wr_ptr_next = pwdata[trs_pkg::PTR_W-1:0];
    end else if (store) begin
      wr_ptr_next = wr_ptr_reg + trs_pkg::PTR_ONE;
    end
  end

  // pointer register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= trs_pkg::PTR_ZERO;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
    end
  end

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  trs_trace_ram u_ram (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (store),
    .wr_addr (wr_ptr_reg),
    .wr_data (formatter_word),
    .rd_en   (fetch),
    .rd_addr (rd_ptr_next),
    .rd_data (ram_q)
  );

  trs_status u_status (
    .mclk                   (mclk),
    .reset                  (reset),
    .capture_enable         (capture_enable),
    .formatter_halted       (formatter_halted),
    .formatter_pipe_drained (formatter_pipe_drained),
    .trigger_embedded       (trigger_embedded),
    .wrap_pulse             (wrap_pulse),
    .full_clear             (wr_idx_load),
    .status                 (status)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = trs_pkg::ZERO_WORD;
    rdata_err  = 1'b0;
    case (paddr)
      trs_pkg::OFF_DEPTH: begin
        rdata_next = trs_pkg::DEPTH_WORDS;
      end
      trs_pkg::OFF_STATUS: begin
        rdata_next = trs_pkg::DATA_W'(status);
      end
      trs_pkg::OFF_WORD: begin
        rdata_next = running ? trs_pkg::READ_ERR : read_word_reg;
      end
      trs_pkg::OFF_RD_IDX: begin
        rdata_next = trs_pkg::DATA_W'(rd_ptr_reg);
      end
      trs_pkg::OFF_WR_IDX: begin
        rdata_next = trs_pkg::DATA_W'(wr_ptr_reg);
      end
      default: begin
        rdata_err  = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB response, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access && rdata_err;
    end
  end

  // read data register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata <= trs_pkg::ZERO_WORD;
    end else if (host_rd) begin
      prdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_idx_load;
    host_wr && paddr == trs_pkg::OFF_RD_IDX && !running;
  endsequence

  sequence s_word_fetched;
    ##2 read_word_reg == $past(ram_q);
  endsequence

  error_read_a: assert property (
    word_read && running |=> pready && prdata == trs_pkg::READ_ERR)
    else $error("error read did not return all ones");

  error_hold_a: assert property (
    word_read && running |=> $stable(rd_ptr_reg))
    else $error("read pointer moved on error read");

  auto_incr_a: assert property (
    word_read && !running |=> rd_ptr_reg == $past(rd_ptr_reg) + trs_pkg::PTR_ONE)
    else $error("read pointer did not advance");

  word_value_a: assert property (
    word_read && !running |=> prdata == $past(read_word_reg))
    else $error("read word value wrong");

  idx_load_a: assert property (
    s_idx_load |=> rd_ptr_reg == $past(pwdata[trs_pkg::PTR_W-1:0]) ##0 s_word_fetched)
    else $error("read pointer load or refetch failed");

  rd_frozen_a: assert property (
    host_wr && paddr == trs_pkg::OFF_RD_IDX && running |=> $stable(rd_ptr_reg))
    else $error("read pointer written during capture");

  wr_frozen_a: assert property (
    host_wr && paddr == trs_pkg::OFF_WR_IDX && running && !formatter_word_valid
    |=> $stable(wr_ptr_reg))
    else $error("write pointer written during capture");

  wr_step_a: assert property (
    store |=> wr_ptr_reg == $past(wr_ptr_reg) + trs_pkg::PTR_ONE)
    else $error("write pointer did not advance");

  full_wrap_a: assert property (
    store && wr_ptr_reg == trs_pkg::PTR_MAX |=> wr_ptr_reg == trs_pkg::PTR_ZERO ##1 status.ram_full)
    else $error("wrap did not set full");

  // ----------------------------------------------------------------
  // read back, hold and response checks
  // ----------------------------------------------------------------
  sequence s_rd_idx_read;
    host_rd && paddr == trs_pkg::OFF_RD_IDX;
  endsequence

  sequence s_wr_idx_read;
    host_rd && paddr == trs_pkg::OFF_WR_IDX;
  endsequence

  // drained flag tracks the formatter one cycle late
  drained_follow_a: assert property (
    !$past(reset)
    |-> status.pipe_drained == $past(formatter_pipe_drained))
    else $error("drained flag does not follow formatter");

  // read mux returns status, depth and pointer registers as they stand
  status_read_a: assert property (
    host_rd && paddr == trs_pkg::OFF_STATUS
    |=> prdata == trs_pkg::DATA_W'($past(status)))
    else $error("status read back wrong");

  rd_idx_read_a: assert property (
    s_rd_idx_read
    |=> prdata == trs_pkg::DATA_W'($past(rd_ptr_reg)))
    else $error("read pointer read back wrong");

  wr_idx_read_a: assert property (
    s_wr_idx_read
    |=> prdata == trs_pkg::DATA_W'($past(wr_ptr_reg)))
    else $error("write pointer read back wrong");

  depth_read_a: assert property (
    host_rd && paddr == trs_pkg::OFF_DEPTH
    |=> prdata == trs_pkg::DEPTH_WORDS)
    else $error("depth read back wrong");

  wr_load_a: assert property (
    host_wr && paddr == trs_pkg::OFF_WR_IDX && !running
    |=> wr_ptr_reg == $past(pwdata[trs_pkg::PTR_W-1:0]))
    else $error("write pointer load failed");

  // pointers move only on loads, word reads and stores
  wr_hold_a: assert property (
    !store && !wr_idx_load
    |=> $stable(wr_ptr_reg))
    else $error("write pointer moved without cause");

  rd_hold_a: assert property (
    !rd_idx_load && !(word_read && !running)
    |=> $stable(rd_ptr_reg))
    else $error("read pointer moved without cause");

  ready_pulse_a: assert property (
    access
    |=> pready ##1 !pready)
    else $error("ready is not a single pulse");

  slverr_flag_a: assert property (
    access && rdata_err
    |=> pready && pslverr)
    else $error("unmapped access without error");

endmodule
`default_nettype wire

/* inc/trs_pkg.sv */
// shared constants and types of the trace RAM status and pointer block
package trs_pkg;

  // ----------------------------------------------------------------
  // widths and depth
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PTR_W  = 10;
  localparam int unsigned DEPTH  = 1024;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_DEPTH  = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_WORD   = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_RD_IDX = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_WR_IDX = 12'h018;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DEPTH_WORDS = 32'h0000_0400;
  localparam logic [DATA_W-1:0] READ_ERR    = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h0000_0000;
  localparam logic [PTR_W-1:0]  PTR_ZERO    = 10'h000;
  localparam logic [PTR_W-1:0]  PTR_ONE     = 10'h001;
  localparam logic [PTR_W-1:0]  PTR_MAX     = 10'h3FF;

  // ----------------------------------------------------------------
  // status flags, msb is bit 3
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pipe_drained;
    logic acquisition_done;
    logic triggered;
    logic ram_full;
  } trs_status_t;

  localparam trs_status_t STATUS_RST = 4'h8;

endpackage

/* hdl/trs_trace_ram.sv */
// single port write, single port read trace memory
`timescale 1ns/1ps
`default_nettype none

module trs_trace_ram (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire logic                       wr_en,
  input  wire logic [trs_pkg::PTR_W-1:0]  wr_addr,
  input  wire logic [trs_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       rd_en,
  input  wire logic [trs_pkg::PTR_W-1:0]  rd_addr,
  output var  logic [trs_pkg::DATA_W-1:0] rd_data
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [trs_pkg::DATA_W-1:0] mem [trs_pkg::DEPTH];

  // formatter word store
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read, one cycle latency
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_data <= trs_pkg::ZERO_WORD;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

/* hdl/trs_status.sv */
// status flag register of the trace buffer
`timescale 1ns/1ps
`default_nettype none

module trs_status (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        capture_enable,
  input  wire logic        formatter_halted,
  input  wire logic        formatter_pipe_drained,
  input  wire logic        trigger_embedded,
  input  wire logic        wrap_pulse,
  input  wire logic        full_clear,
  output var  trs_pkg::trs_status_t status
);

  logic enable_q;
  logic drained_reg;
  logic done_reg;
  logic triggered_reg;
  logic full_reg;

  // ----------------------------------------------------------------
  // flag tracking
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= capture_enable;
    end
  end

  // pipeline and completion mirror the formatter
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      drained_reg <= trs_pkg::STATUS_RST.pipe_drained;
      done_reg    <= trs_pkg::STATUS_RST.acquisition_done;
    end else begin
      drained_reg <= formatter_pipe_drained;
      done_reg    <= formatter_halted;
    end
  end

  // sticky trigger, new session clears, set wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      triggered_reg <= trs_pkg::STATUS_RST.triggered;
    end else if (trigger_embedded) begin
      triggered_reg <= 1'b1;
    end else if (capture_enable && !enable_q) begin
      triggered_reg <= 1'b0;
    end
  end

  // sticky full on pointer wrap, set wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      full_reg <= trs_pkg::STATUS_RST.ram_full;
    end else if (wrap_pulse) begin
      full_reg <= 1'b1;
    end else if (full_clear) begin
      full_reg <= 1'b0;
    end
  end

  // flags gathered into one status word, bit 3 first
  assign status = {drained_reg, done_reg, triggered_reg, full_reg};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  acq_follows_a: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> status.acquisition_done == $past(formatter_halted))
    else $error("completion flag does not follow halted");

  trig_sticky_a: assert property (@(posedge mclk) disable iff (reset)
    trigger_embedded |=> status.triggered)
    else $error("trigger not recorded");

endmodule
`default_nettype wire

/* dv/trs_fmt_model.sv */
// formatter stand-in that feeds numbered trace words to the block
`timescale 1ns/1ps
`default_nettype none

module trs_fmt_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        capture_enable,
  input  wire logic        send,
  input  wire logic        trig_req,
  output var  logic        formatter_halted,
  output var  logic        formatter_pipe_drained,
  output var  logic        formatter_word_valid,
  output var  logic [31:0] formatter_word,
  output var  logic        trigger_embedded,
  output var  logic [15:0] sent
);
  logic [1:0] flush_reg;

  // ----------------------------------------------------------------
  // halt control
  // ----------------------------------------------------------------
  // halts only after a short flush once enable drops
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      formatter_halted <= 1'b1;
      flush_reg        <= 2'h0;
    end else if (capture_enable) begin
      formatter_halted <= 1'b0;
      flush_reg        <= 2'h2;
    end else if (flush_reg != 2'h0) begin
      flush_reg <= flush_reg - 2'h1;
    end else begin
      formatter_halted <= 1'b1;
    end
  end

  // one numbered word per cycle on request; idle data toggles
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      formatter_word_valid <= 1'b0;
      formatter_word       <= 32'h0000_0000;
      sent                 <= 16'h0000;
    end else if (send && capture_enable && !formatter_halted) begin
      formatter_word_valid <= 1'b1;
      formatter_word       <= {16'hC0DE, sent};
      sent                 <= sent + 16'h0001;
    end else begin
      formatter_word_valid <= 1'b0;
      formatter_word       <= ~formatter_word;
    end
  end

  // trigger marker pulse, only while capturing
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      trigger_embedded <= 1'b0;
    end else begin
      trigger_embedded <= trig_req && capture_enable;
    end
  end

  // pipeline holds data while words are being sent
  assign formatter_pipe_drained = !(send && capture_enable) && !formatter_word_valid;
endmodule
`default_nettype wire

/* dv/trs_trace_regs_test.sv */
// self-checking bench of the trace status and pointer registers
`timescale 1ns/1ps
`default_nettype none

module trs_trace_regs_test;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        capture_enable = 1'b0;
  logic        send = 1'b0;
  logic        trig_req = 1'b0;
  logic        halted, drained, wvalid, trig;
  logic [31:0] fword;
  logic [15:0] sent;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  trs_trace_regs i_trs_trace_regs (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_enable(capture_enable), .formatter_halted(halted),
    .formatter_pipe_drained(drained), .formatter_word_valid(wvalid),
    .formatter_word(fword), .trigger_embedded(trig));

  trs_fmt_model i_trs_fmt_model (.mclk(mclk), .reset(reset),
    .capture_enable(capture_enable), .send(send), .trig_req(trig_req),
    .formatter_halted(halted), .formatter_pipe_drained(drained),
    .formatter_word_valid(wvalid), .formatter_word(fword),
    .trigger_embedded(trig), .sent(sent));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #20 mclk = ~mclk;

  // cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      $display("wrong value at %0t: run timed out", $time);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; ready, data and error are taken at the edge that samples ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: no ready", $time);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_idle();
    rchk(trs_pkg::OFF_DEPTH, trs_pkg::DEPTH_WORDS);
    rchk(trs_pkg::OFF_STATUS, 32'h0000_000C);
    rchk(trs_pkg::OFF_RD_IDX, 32'h0000_0000);
    rchk(trs_pkg::OFF_WR_IDX, 32'h0000_0000);
    wr(trs_pkg::OFF_RD_IDX, 32'hFFFF_FC05);
    rchk(trs_pkg::OFF_RD_IDX, 32'h0000_0005);
  endtask

  task automatic t_capture();
    logic [31:0] q;
    logic        e;
    wr(trs_pkg::OFF_WR_IDX, 32'hFFFF_FFFC);
    rchk(trs_pkg::OFF_WR_IDX, 32'h0000_03FC);
    capture_enable <= 1'b1;
    repeat (3) @(posedge mclk);
    send <= 1'b1;
    repeat (6) @(posedge mclk);
    apb(1'b0, trs_pkg::OFF_STATUS, 32'h0000_0000, q, e);
    chk(q & 32'h0000_000C, 32'h0000_0000);
    send <= 1'b0;
    repeat (4) @(posedge mclk);
    rchk(trs_pkg::OFF_WR_IDX, (32'h0000_03FC + {16'h0000, sent}) & 32'h0000_03FF);
    rchk(trs_pkg::OFF_STATUS, 32'h0000_0009);
    trig_req <= 1'b1;
    @(posedge mclk);
    trig_req <= 1'b0;
    repeat (3) @(posedge mclk);
    rchk(trs_pkg::OFF_STATUS, 32'h0000_000B);
    rchk(trs_pkg::OFF_WORD, trs_pkg::READ_ERR);
    rchk(trs_pkg::OFF_RD_IDX, 32'h0000_0005);
    wr(trs_pkg::OFF_RD_IDX, 32'h0000_0123);
    rchk(trs_pkg::OFF_RD_IDX, 32'h0000_0005);
    wr(trs_pkg::OFF_WR_IDX, 32'h0000_0111);
    rchk(trs_pkg::OFF_WR_IDX, (32'h0000_03FC + {16'h0000, sent}) & 32'h0000_03FF);
    capture_enable <= 1'b0;
    repeat (6) @(posedge mclk);
    rchk(trs_pkg::OFF_STATUS, 32'h0000_000F);
  endtask

  task automatic t_readback();
    wr(trs_pkg::OFF_RD_IDX, 32'h0000_03FE);
    rchk(trs_pkg::OFF_WORD, 32'hC0DE_0002);
    rchk(trs_pkg::OFF_WORD, 32'hC0DE_0003);
    rchk(trs_pkg::OFF_WORD, 32'hC0DE_0004);
    rchk(trs_pkg::OFF_RD_IDX, 32'h0000_0001);
  endtask

  task automatic t_unmapped();
    logic [31:0] q;
    logic        e;
    apb(1'b0, 12'h020, 32'h0000_0000, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(q, trs_pkg::ZERO_WORD);
    wr(trs_pkg::OFF_DEPTH, 32'h0000_0000);
    rchk(trs_pkg::OFF_DEPTH, trs_pkg::DEPTH_WORDS);
  endtask

  // mid-run reset clears pointers and sticky flags
  task automatic t_reset();
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rchk(trs_pkg::OFF_RD_IDX, 32'h0000_0000);
    rchk(trs_pkg::OFF_WR_IDX, 32'h0000_0000);
    rchk(trs_pkg::OFF_STATUS, 32'h0000_000C);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_idle();
    t_capture();
    t_readback();
    t_unmapped();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
